//--- core/metering_ram_map.sv
// Word-addressed register and data RAM map of the metering engine.
// What this block does
// RL1 - Metering clock 6553.6kHz, converter clock one eighth.
// RL2 - Every register moves as one 32-bit word.
// RL3 - Host sets parameter word, then clears scratch RAM.
// RL4 - 0xD000-0xD00B accumulators readable and writable.
// RL5 - 0xE800-0xE9A7 results and calibration, read/write.
// RL6 - 0xEC00-0xEC52 configuration and state, read/write.
// RL7 - Host never touches the reserved ranges; the bench writes and reads six reserved words on purpose.
// RL8 - DC words read back sign-extended from bit 23.
// RL9 - Neutral channel has no power-type results.
// RL10 - Reserved addresses read zero, ignore writes.
`timescale 1ns/10ps
module metering_ram_map
    import metering_map_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic NORMAL_OP_MODE,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic WR_EN,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic RD_EN,
    output logic [DATA_W-1:0] RDATA,
    output logic RD_VALID,
    output logic [DATA_W-1:0] METERING_PARAM_CTRL0,
    output logic MTR_TICK,
    output logic ADC_TICK
);
    logic [DATA_W-1:0] scr_mem [0:2*SCR_WORDS-1];
    logic [DATA_W-1:0] hse_mem [0:HSE_WORDS-1];
    logic [DATA_W-1:0] met_mem [0:MET_WORDS-1];
    logic [DATA_W-1:0] cfg_mem [0:CFG_WORDS-1];
    logic [DC_W-1:0] dc_mem [0:DC_WORDS-1];

    logic [DATA_W-1:0] param0_ff;
    logic [DATA_W-1:0] nxt_param0;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic rd_valid_ff;
    logic nxt_rd_valid;

    region_t region;
    logic [15:0] off;
    logic [SCR_IDX_W:0] scr_idx;
    logic [HSE_IDX_W-1:0] hse_idx;
    logic [MET_IDX_W-1:0] met_idx;
    logic [CFG_IDX_W-1:0] cfg_idx;
    logic [DC_IDX_W-1:0] dc_idx;
    logic [DC_W-1:0] dc_word;

    logic wr_scr;
    logic wr_hse;
    logic wr_met;
    logic wr_cfg;
    logic wr_dc;

    // Address decode. Anything outside the mapped windows, the reserved
    // ranges among them, falls into RG_NONE.
    always_comb begin
        region = RG_NONE;
        off = 16'h0000;
        if (ADDR == PARAM0_ADDR) begin
            region = RG_PARAM;
        end else if (ADDR >= SCR0_BASE && ADDR <= SCR0_LAST) begin
            region = RG_SCR;
            off = ADDR - SCR0_BASE;
        end else if (ADDR >= SCR1_BASE && ADDR <= SCR1_LAST) begin
            region = RG_SCR;
            off = ADDR - SCR1_BASE + 16'(SCR_WORDS);
        end else if (ADDR >= HSE_BASE && ADDR <= HSE_LAST) begin // [RL4]
            region = RG_HSE;
            off = ADDR - HSE_BASE;
        end else if (ADDR >= MET_BASE && ADDR <= MET_LAST) begin // [RL5]
            region = RG_MET;
            off = ADDR - MET_BASE;
        end else if (ADDR >= CFG_BASE && ADDR <= CFG_LAST) begin // [RL6]
            region = RG_CFG;
            off = ADDR - CFG_BASE;
        end else if (ADDR >= DC_BASE && ADDR <= DC_LAST) begin // [RL8]
            region = RG_DC;
            off = ADDR - DC_BASE;
        end
    end

    assign scr_idx = off[SCR_IDX_W:0];
    assign hse_idx = off[HSE_IDX_W-1:0];
    assign met_idx = off[MET_IDX_W-1:0];
    assign cfg_idx = off[CFG_IDX_W-1:0];
    assign dc_idx = off[DC_IDX_W-1:0];
    assign dc_word = dc_mem[dc_idx];

    // Writes into unmapped space raise no strobe at all. [RL10]
    always_comb begin
        wr_scr = WR_EN && region == RG_SCR; // [RL3]
        wr_hse = WR_EN && region == RG_HSE; // [RL4]
        wr_met = WR_EN && region == RG_MET; // [RL5]
        wr_cfg = WR_EN && region == RG_CFG; // [RL6]
        wr_dc = WR_EN && region == RG_DC; // [RL8]
        nxt_param0 = param0_ff;
        if (WR_EN && region == RG_PARAM) begin
            nxt_param0 = WDATA; // [RL2]
        end
    end

    // Read path. A read in the same cycle as a write to the same word
    // returns the old contents; the new value shows from the next access.
    // The map offers no neutral-channel power, phase, frequency or power
    // factor words, so such results cannot be addressed. [RL9]
    always_comb begin
        nxt_rd_valid = RD_EN;
        nxt_rdata = rdata_ff;
        if (RD_EN) begin
            case (region)
                RG_PARAM: nxt_rdata = param0_ff; // [RL2]
                RG_SCR:   nxt_rdata = scr_mem[scr_idx];
                RG_HSE:   nxt_rdata = hse_mem[hse_idx]; // [RL4]
                RG_MET:   nxt_rdata = met_mem[met_idx]; // [RL5]
                RG_CFG:   nxt_rdata = cfg_mem[cfg_idx]; // [RL6]
                RG_DC:    nxt_rdata = {{(DATA_W-DC_W){dc_word[DC_SIGN_BIT]}}, dc_word}; // [RL8]
                default:  nxt_rdata = '0; // [RL10]
            endcase
        end
    end

    // The RAM arrays carry no reset; software clears only the scratch RAM during start-up.
    always_ff @(posedge CORE_CLK) begin
        if (wr_scr) begin
            scr_mem[scr_idx] <= WDATA;
        end
        if (wr_hse) begin
            hse_mem[hse_idx] <= WDATA;
        end
        if (wr_met) begin
            met_mem[met_idx] <= WDATA;
        end
        if (wr_cfg) begin
            cfg_mem[cfg_idx] <= WDATA;
        end
        if (wr_dc) begin
            dc_mem[dc_idx] <= WDATA[DC_W-1:0]; // [RL8]
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            param0_ff <= PARAM0_RESET;
            rdata_ff <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            param0_ff <= nxt_param0;
            rdata_ff <= nxt_rdata;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign RDATA = rdata_ff;
    assign RD_VALID = rd_valid_ff;
    assign METERING_PARAM_CTRL0 = param0_ff;

    // Clock enables run only in the normal operating mode.
    metering_tick_gen u_tick (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .run(NORMAL_OP_MODE),
        .mtr_tick_ff(MTR_TICK),
        .adc_tick_ff(ADC_TICK)
    );

    a_unmapped_reads_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL10]
        RD_EN && region == RG_NONE |=> RD_VALID && RDATA == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    a_dc_sign_extend: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL8]
        RD_EN && region == RG_DC |=> RDATA[31:24] == {8{RDATA[23]}})
        else $error("DC word not sign-extended");
    a_rd_valid_once: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL2]
        RD_VALID == $past(RD_EN))
        else $error("read valid timing wrong");
    a_param_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL2]
        WR_EN && region == RG_PARAM ##1 RD_EN && !WR_EN && region == RG_PARAM
        |=> RDATA == $past(WDATA, 2))
        else $error("parameter word readback mismatch");
    a_hse_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL4]
        WR_EN && region == RG_HSE ##1 RD_EN && !WR_EN && ADDR == $past(ADDR)
        |=> RDATA == $past(WDATA, 2))
        else $error("accumulator readback mismatch");
    a_met_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL5]
        WR_EN && region == RG_MET ##1 RD_EN && !WR_EN && ADDR == $past(ADDR)
        |=> RDATA == $past(WDATA, 2))
        else $error("calibration readback mismatch");
    a_cfg_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL6]
        WR_EN && region == RG_CFG ##1 RD_EN && !WR_EN && ADDR == $past(ADDR)
        |=> RDATA == $past(WDATA, 2))
        else $error("configuration readback mismatch");
    a_unmapped_write_none: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL10]
        WR_EN && region == RG_NONE |=> $stable(METERING_PARAM_CTRL0))
        else $error("unmapped write changed state");
    a_ticks_need_mode: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RL1]
        !NORMAL_OP_MODE |=> !MTR_TICK && !ADC_TICK)
        else $error("tick outside normal mode");
endmodule : metering_ram_map

//--- core/metering_map_pkg.sv
// Address map, widths and timing constants of the metering RAM map.
package metering_map_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int DC_W = 24;
    localparam int DC_SIGN_BIT = 23;

    // Configuration word and the scratch RAM that software clears at start-up.
    localparam logic [15:0] PARAM0_ADDR = 16'hC000;
    localparam logic [31:0] PARAM0_RESET = 32'h0000_0000;
    localparam logic [31:0] PARAM0_INIT_VALUE = 32'h1000_0000;
    localparam logic [15:0] SCR0_BASE = 16'hC800;
    localparam logic [15:0] SCR0_LAST = 16'hC837;
    localparam logic [15:0] SCR1_BASE = 16'hC880;
    localparam logic [15:0] SCR1_LAST = 16'hC8B7;
    localparam int SCR_WORDS = 56;
    localparam int SCR_IDX_W = 6;

    // High-speed energy accumulators and pulse counter.
    localparam logic [15:0] HSE_BASE = 16'hD000;
    localparam logic [15:0] HSE_LAST = 16'hD00B;
    localparam int HSE_WORDS = 12;
    localparam int HSE_IDX_W = 4;

    // Metering results and calibration.
    localparam logic [15:0] MET_BASE = 16'hE800;
    localparam logic [15:0] MET_LAST = 16'hE9A7;
    localparam int MET_WORDS = 424;
    localparam int MET_IDX_W = 9;

    // Configuration and system state.
    localparam logic [15:0] CFG_BASE = 16'hEC00;
    localparam logic [15:0] CFG_LAST = 16'hEC52;
    localparam int CFG_WORDS = 83;
    localparam int CFG_IDX_W = 7;

    // DC-component words, 24 bits wide.
    localparam logic [15:0] DC_BASE = 16'hF02C;
    localparam logic [15:0] DC_LAST = 16'hF032;
    localparam int DC_WORDS = 7;
    localparam int DC_IDX_W = 3;

    // Metering clock and converter clock rates.
    localparam longint CORE_FREQ_HZ = 100000000;
    localparam longint MTR_FREQ_HZ = 6553600;
    localparam int ADC_DIV = 8;
    localparam int RATE_SCALE = 100;
    localparam int ACC_W = 21;
    localparam logic [ACC_W-1:0] MTR_INC = ACC_W'(MTR_FREQ_HZ / RATE_SCALE);
    localparam logic [ACC_W-1:0] MTR_MOD = ACC_W'(CORE_FREQ_HZ / RATE_SCALE);
    localparam int MTR_MIN_GAP = int'(CORE_FREQ_HZ / MTR_FREQ_HZ);

    typedef enum logic [2:0] {
        RG_NONE  = 3'h0,
        RG_PARAM = 3'h1,
        RG_SCR   = 3'h3,
        RG_HSE   = 3'h2,
        RG_MET   = 3'h6,
        RG_CFG   = 3'h7,
        RG_DC    = 3'h5
    } region_t;
endpackage : metering_map_pkg

//--- core/metering_tick_gen.sv
// Fractional divider making the metering and converter clock enables.
`timescale 1ns/10ps
module metering_tick_gen
    import metering_map_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic mtr_tick_ff,
    output logic adc_tick_ff
);
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] nxt_acc;
    logic [2:0] adc_cnt_ff;
    logic [2:0] nxt_adc_cnt;
    logic nxt_mtr_tick;
    logic nxt_adc_tick;
    logic [ACC_W-1:0] sum;

    // The rate ratio is exact, so long-term tick count carries no drift.
    always_comb begin
        sum = acc_ff + MTR_INC;
        nxt_acc = acc_ff;
        nxt_adc_cnt = adc_cnt_ff;
        nxt_mtr_tick = 1'b0;
        nxt_adc_tick = 1'b0;
        if (run) begin
            nxt_acc = sum;
            if (sum >= MTR_MOD) begin // [RL1]
                nxt_acc = sum - MTR_MOD;
                nxt_mtr_tick = 1'b1;
                nxt_adc_cnt = adc_cnt_ff + 3'h1;
                nxt_adc_tick = (adc_cnt_ff == 3'(ADC_DIV - 1)); // [RL1]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= '0;
            adc_cnt_ff <= 3'h0;
            mtr_tick_ff <= 1'b0;
            adc_tick_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            adc_cnt_ff <= nxt_adc_cnt;
            mtr_tick_ff <= nxt_mtr_tick;
            adc_tick_ff <= nxt_adc_tick;
        end
    end

    a_mtr_tick_gap: assert property (@(posedge clk) disable iff (!rst_n)
        mtr_tick_ff |=> !mtr_tick_ff [*8]) // [RL1]
        else $error("metering tick came too soon");
    a_adc_with_mtr: assert property (@(posedge clk) disable iff (!rst_n)
        adc_tick_ff |-> mtr_tick_ff && $past(adc_cnt_ff) == 3'(ADC_DIV - 1)) // [RL1]
        else $error("converter tick not on eighth metering tick");
endmodule : metering_tick_gen

//--- verification/host_model.sv
// Host model that drives the word port of the metering RAM map.
`timescale 1ns/10ps
module host_model
    import metering_map_pkg::*;
(
    input wire logic clk,
    output logic [ADDR_W-1:0] addr,
    output logic wr_en,
    output logic [DATA_W-1:0] wdata,
    output logic rd_en,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rd_valid
);
    initial begin
        addr = 16'h0000;
        wdata = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // Idle lines show the inverse of their last value, so nothing can lean on stale data.
    task automatic release_bus();
        addr = ~addr;
        wdata = ~wdata;
    endtask : release_bus

    // One 32-bit word per access, taken at the rising edge inside the strobe.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        release_bus();
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        d = rdata;
        v = rd_valid;
        rd_en = 1'b0;
        release_bus();
    endtask : rd

    // Write and read of one word in consecutive cycles, so the read sees the fresh word.
    task automatic wr_rd(input logic [15:0] a, input logic [31:0] d, output logic [31:0] q, output logic v);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(negedge clk);
        q = rdata;
        v = rd_valid;
        rd_en = 1'b0;
        release_bus();
    endtask : wr_rd

    // Parameter word first, then both scratch ranges cleared; reserved ranges are
    // only touched when the bench asks for a stray access on purpose.
    task automatic init_engine();
        wr(PARAM0_ADDR, PARAM0_INIT_VALUE);
        for (int i = 0; i < SCR_WORDS; i++) begin
            wr(SCR0_BASE + 16'(i), 32'h0000_0000);
            wr(SCR1_BASE + 16'(i), 32'h0000_0000);
        end
    endtask : init_engine
endmodule : host_model

//--- verification/tb_top.sv
// Self-checking testbench of the metering RAM map.
`timescale 1ns/10ps
module tb_top;
    import metering_map_pkg::*;
    logic core_clk;
    logic rst_n;
    logic mode;
    logic [ADDR_W-1:0] addr;
    logic wr_en;
    logic [DATA_W-1:0] wdata;
    logic rd_en;
    logic [DATA_W-1:0] rdata;
    logic rd_valid;
    logic [DATA_W-1:0] param;
    logic mtr_tick;
    logic adc_tick;
    logic [31:0] got;
    logic vld;
    int n_mismatch = 0;
    int checked = 0;
    int n_mtr = 0;
    int n_adc = 0;
    int cyc = 0;
    int last_mtr = -1;
    int min_gap = 1000;
    logic [15:0] edges [6] = '{HSE_BASE, HSE_LAST, MET_BASE, MET_LAST, CFG_BASE, CFG_LAST};
    logic [15:0] stray [6] = '{16'hE000, 16'hE9A8, 16'hF000, 16'hF033, 16'hF800, 16'hD00C};

    metering_ram_map uut (.CORE_CLK(core_clk), .RST_N(rst_n), .NORMAL_OP_MODE(mode), .ADDR(addr),
        .WR_EN(wr_en), .WDATA(wdata), .RD_EN(rd_en), .RDATA(rdata), .RD_VALID(rd_valid),
        .METERING_PARAM_CTRL0(param), .MTR_TICK(mtr_tick), .ADC_TICK(adc_tick));

    host_model host (.clk(core_clk), .addr(addr), .wr_en(wr_en), .wdata(wdata), .rd_en(rd_en),
        .rdata(rdata), .rd_valid(rd_valid));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Ticks are counted on the falling edge, where the registered pulses have settled.
    always @(negedge core_clk) begin
        cyc++;
        if (mtr_tick === 1'b1) begin
            if (last_mtr >= 0 && cyc - last_mtr < min_gap) begin
                min_gap = cyc - last_mtr;
            end
            last_mtr = cyc;
            n_mtr++;
        end
        if (adc_tick === 1'b1) begin
            n_adc++;
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
        host.rd(a, got, vld);
        chk({what, " valid"}, {31'h0, vld}, 32'h0000_0001);
        chk(what, got, exp);
    endtask : rd_chk

    task automatic wr_rd_chk(input string what, input logic [15:0] a, input logic [31:0] d);
        host.wr_rd(a, d, got, vld);
        chk({what, " valid"}, {31'h0, vld}, 32'h0000_0001);
        chk(what, got, d);
    endtask : wr_rd_chk

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #700_000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        mode = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("param at reset", param, PARAM0_RESET);
        rst_n = 1'b1;
        host.init_engine();
        chk("param after init", param, PARAM0_INIT_VALUE);
        wr_rd_chk("param back to back", PARAM0_ADDR, PARAM0_INIT_VALUE);
        rd_chk("scratch tail", SCR1_LAST, 32'h0000_0000);
        chk("ticks while stopped", 32'(n_mtr), 32'h0000_0000);
        foreach (edges[i]) begin
            host.wr(edges[i], {edges[i], ~edges[i]});
            rd_chk("mapped word", edges[i], {edges[i], ~edges[i]});
            wr_rd_chk("mapped back to back", edges[i], {~edges[i], edges[i]});
        end
        host.wr(DC_BASE, 32'hAB80_0001);
        rd_chk("dc negative", DC_BASE, 32'hFF80_0001);
        host.wr(DC_LAST, 32'h127F_FFFF);
        rd_chk("dc positive", DC_LAST, 32'h007F_FFFF);
        foreach (stray[i]) begin
            host.wr(stray[i], 32'hFFFF_FFFF);
            rd_chk("reserved word", stray[i], 32'h0000_0000);
        end
        // The stray write just past the accumulators must not alias onto them.
        rd_chk("accumulator kept", HSE_LAST, {~HSE_LAST, HSE_LAST});
        mode = 1'b1;
        repeat (50000) @(negedge core_clk);
        mode = 1'b0;
        // 50000 core cycles hold 3276.8 metering periods, so either neighbour is legal.
        chk("metering rate", {31'h0, n_mtr inside {[3276:3277]}}, 32'h0000_0001);
        chk("adc ratio", {31'h0, n_adc inside {[n_mtr / ADC_DIV:(n_mtr + 7) / ADC_DIV]}}, 32'h0000_0001);
        chk("tick spacing", {31'h0, min_gap >= MTR_MIN_GAP}, 32'h0000_0001);
        // A reset after the run clears the registers but leaves the RAM words alone.
        rst_n = 1'b0;
        @(negedge core_clk);
        chk("param after reset", param, PARAM0_RESET);
        chk("valid after reset", {31'h0, rd_valid}, 32'h0000_0000);
        rst_n = 1'b1;
        rd_chk("accumulator after reset", HSE_BASE, {~HSE_BASE, HSE_BASE});
        report_and_stop();
    end
endmodule : tb_top
